/* File: tcdma_regs.vh */
// register offsets, field positions, select and area codes and reset values of the two-channel dma controller
`ifndef TCDMA_REGS_VH
`define TCDMA_REGS_VH

// ******************************************************************
// register byte offsets, per channel stride 0x20
// ******************************************************************
`define TCDMA_CH_STRIDE   8'h20
`define TCDMA_OFF_CTRL    8'h00
`define TCDMA_OFF_SEL     8'h04
`define TCDMA_OFF_SRC     8'h08
`define TCDMA_OFF_DST     8'h0C
`define TCDMA_OFF_RLD     8'h10
`define TCDMA_OFF_CNT     8'h14
`define TCDMA_OFF_PTR     8'h18
`define TCDMA_OFF_BUSCFG  8'h40

// ******************************************************************
// control register fields
// ******************************************************************
`define TCDMA_CTRL_EN     0
`define TCDMA_CTRL_REQ    1
`define TCDMA_CTRL_UNIT8  2
`define TCDMA_CTRL_RPT    3
`define TCDMA_CTRL_SFWD   4
`define TCDMA_CTRL_DFWD   5
`define TCDMA_CTRL_SWTRG  6
`define TCDMA_CTRL_DONE   7

// ******************************************************************
// request source select codes
// ******************************************************************
`define TCDMA_SEL_SW      4'h0
`define TCDMA_SEL_EXTFALL 4'h1
`define TCDMA_SEL_EXTBOTH 4'h2
`define TCDMA_SEL_PERI0   4'h8

// ******************************************************************
// bus configuration fields and area codes
// ******************************************************************
`define TCDMA_CFG_SINGLE  0
`define TCDMA_CFG_BUS8    1
`define TCDMA_AREA_INT    3'h0
`define TCDMA_AREA_INTW   3'h1
`define TCDMA_AREA_SFA    3'h2
`define TCDMA_AREA_SEP    3'h3
`define TCDMA_AREA_SEPW   3'h4
`define TCDMA_AREA_MUX    3'h5

// ******************************************************************
// reset values
// ******************************************************************
`define TCDMA_RST_CTRL    8'h00
`define TCDMA_RST_BUSCFG  32'h0000_0001

`endif

/* File: tcdma_weight.v */
// cycle weight of one bus cycle by memory area
`timescale 1ns/100ps
`include "tcdma_regs.vh"
module tcdma_weight (
   input  wire [2:0] area_i,    // area code of the access
   output reg  [1:0] weight_o   // clocks per bus cycle
);
   // unknown codes fall back to the slowest known weight minus one
   always @* begin
      case (area_i)
         `TCDMA_AREA_INT  : weight_o = 2'h1;
         `TCDMA_AREA_SEP  : weight_o = 2'h1;
         `TCDMA_AREA_INTW : weight_o = 2'h2;
         `TCDMA_AREA_SFA  : weight_o = 2'h2;
         `TCDMA_AREA_SEPW : weight_o = 2'h2;
         `TCDMA_AREA_MUX  : weight_o = 2'h3;
         default          : weight_o = 2'h2;
      endcase
   end
endmodule // tcdma_weight

/* File: tcdma_sync.v */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
module tcdma_sync (
   input  wire clock_i,     // bus clock
   input  wire reset_n_i,   // async reset, active low
   input  wire pin_i,       // asynchronous pin
   output reg  level_o      // filtered level
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   // level changes only once stages two and three agree
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_q    <= 1'b1;
         s2_q    <= 1'b1;
         s3_q    <= 1'b1;
         level_o <= 1'b1;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_o <= s3_q;
         end
      end
   end
endmodule // tcdma_sync

/* File: tcdma_top.v */
// two-channel dma controller with apb register slave and system bus master port
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "tcdma_regs.vh"
module tcdma_top #(
   parameter NPERI = 8                     // peripheral request lines
) (
   input  wire              clock_i,       // bus clock, 125 MHz
   input  wire              reset_n_i,     // async reset, active low
   input  wire              psel_i,        // apb select
   input  wire              penable_i,     // apb enable
   input  wire              pwrite_i,      // apb direction
   input  wire [7:0]        paddr_i,       // apb byte address
   input  wire [31:0]       pwdata_i,      // apb write data
   output reg  [31:0]       prdata_o,      // apb read data
   output reg               pready_o,      // apb ready
   output reg               pslverr_o,     // apb error, unmapped address
   input  wire [NPERI-1:0]  peri_irq_i,    // peripheral interrupt flag set pulses
   input  wire [1:0]        ext_int_i,     // external_interrupt_input pins
   input  wire              cpu_access_i,  // cpu finished one bus access
   output reg               bus_req_o,     // dma owns the system bus
   output reg               mem_rd_o,      // bus read strobe
   output reg               mem_wr_o,      // bus write strobe
   output reg               mem_byte_o,    // byte wide bus cycle
   output reg  [19:0]       mem_addr_o,    // bus address
   output reg  [15:0]       mem_wdata_o,   // bus write data
   input  wire [15:0]       mem_rdata_i,   // bus read data
   output reg  [1:0]        done_irq_o     // counter underflow pulse per channel
);
   // ******************************************************************
   // state codes
   // ******************************************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_RD   = 2'h1;
   localparam ST_WR   = 2'h2;
   localparam ST_GAP  = 2'h3;

   reg  [7:0]  ctrl_q   [0:1];
   reg  [3:0]  sel_q    [0:1];
   reg  [19:0] src_q    [0:1];
   reg  [19:0] dst_q    [0:1];
   reg  [15:0] rld_q    [0:1];
   reg  [15:0] cnt_q    [0:1];
   reg  [19:0] ptr_q    [0:1];
   reg  [1:0]  fresh_q;
   reg  [31:0] cfg_q;
   reg  [1:0]  st_q;
   reg         ch_q;
   reg         gap_q;
   reg  [1:0]  phase_q;
   reg  [1:0]  wait_q;
   reg  [15:0] data_q;
   reg  [1:0]  cap_q;
   wire [1:0]  ext_lvl;
   reg  [1:0]  ext_prev_q;
   wire [1:0]  req_ev;
   wire [1:0]  w_src;
   wire [1:0]  w_dst;
   wire        wr_en;
   wire        rd_en;
   wire [2:0]  reg_idx;
   wire        reg_ch;
   wire        start;
   wire        start_ch;
   wire        cur_unit8;
   wire [19:0] cur_src;
   wire [19:0] cur_dst;
   wire        two_cyc;
   reg  [31:0] rd_mux;
   wire [15:0] rd_word;

   assign wr_en   = psel_i & penable_i & pwrite_i;
   assign rd_en   = psel_i & ~penable_i & ~pwrite_i;
   assign reg_idx = paddr_i[4:2];
   assign reg_ch  = paddr_i[5];
   // read data taken one edge after its bus cycle, once the address has reached the bus
   assign rd_word = !cap_q[1] ? data_q : (cap_q[0] ? {mem_rdata_i[7:0], data_q[7:0]} : mem_rdata_i);

   // ******************************************************************
   // request sources
   // ******************************************************************
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_ch
         wire fall;
         wire both;
         tcdma_sync u_sync (
            .clock_i   (clock_i),
            .reset_n_i (reset_n_i),
            .pin_i     (ext_int_i[g]),
            .level_o   (ext_lvl[g])
         );
         assign fall = ext_prev_q[g] & ~ext_lvl[g];
         assign both = ext_prev_q[g] ^ ext_lvl[g];
         assign req_ev[g] =
            (sel_q[g] == `TCDMA_SEL_SW)      ? (wr_en && reg_ch == g && paddr_i[4:0] == `TCDMA_OFF_CTRL &&
                                                paddr_i[7:6] == 2'h0 && pwdata_i[`TCDMA_CTRL_SWTRG]) :
            (sel_q[g] == `TCDMA_SEL_EXTFALL) ? fall :
            (sel_q[g] == `TCDMA_SEL_EXTBOTH) ? both :
            (sel_q[g][3]) ? peri_irq_i[sel_q[g][2:0] % NPERI] : 1'b0;
      end
   endgenerate

   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_prev_q <= 2'h3;
      end else begin
         ext_prev_q <= ext_lvl;
      end
   end

   // ******************************************************************
   // arbitration
   // ******************************************************************
   // channel zero wins; after a transfer wait one cpu access
   assign start    = (st_q == ST_IDLE) && !gap_q &&
                     ((ctrl_q[0][`TCDMA_CTRL_EN] && ctrl_q[0][`TCDMA_CTRL_REQ]) ||
                      (ctrl_q[1][`TCDMA_CTRL_EN] && ctrl_q[1][`TCDMA_CTRL_REQ]));
   assign start_ch = !(ctrl_q[0][`TCDMA_CTRL_EN] && ctrl_q[0][`TCDMA_CTRL_REQ]);

   assign cur_unit8 = ctrl_q[ch_q][`TCDMA_CTRL_UNIT8];
   // forward side reads the working pointer
   assign cur_src = (ctrl_q[ch_q][`TCDMA_CTRL_SFWD]) ? ptr_q[ch_q] : src_q[ch_q];
   assign cur_dst = (ctrl_q[ch_q][`TCDMA_CTRL_DFWD]) ? ptr_q[ch_q] : dst_q[ch_q];
   // two cycles for odd or narrow 16-bit unit
   assign two_cyc = !cur_unit8 && (cfg_q[`TCDMA_CFG_BUS8] && !cfg_q[`TCDMA_CFG_SINGLE] ||
                    (st_q == ST_RD ? cur_src[0] : cur_dst[0]));

   // area weights for source and destination
   tcdma_weight u_wsrc (
      .area_i   (cfg_q[10:8]),
      .weight_o (w_src)
   );
   tcdma_weight u_wdst (
      .area_i   (cfg_q[14:12]),
      .weight_o (w_dst)
   );

   // ******************************************************************
   // transfer engine and register writes
   // ******************************************************************
   integer i;
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (i = 0; i < 2; i = i + 1) begin
            ctrl_q[i] <= `TCDMA_RST_CTRL;
            sel_q[i]  <= 4'h0;
            src_q[i]  <= 20'h0_0000;
            dst_q[i]  <= 20'h0_0000;
            rld_q[i]  <= 16'h0000;
            cnt_q[i]  <= 16'h0000;
            ptr_q[i]  <= 20'h0_0000;
         end
         fresh_q     <= 2'h0;
         cfg_q       <= `TCDMA_RST_BUSCFG;
         st_q        <= ST_IDLE;
         ch_q        <= 1'b0;
         gap_q       <= 1'b0;
         phase_q     <= 2'h0;
         wait_q      <= 2'h0;
         data_q      <= 16'h0000;
         cap_q       <= 2'h0;
         bus_req_o   <= 1'b0;
         mem_rd_o    <= 1'b0;
         mem_wr_o    <= 1'b0;
         mem_byte_o  <= 1'b0;
         mem_addr_o  <= 20'h0_0000;
         mem_wdata_o <= 16'h0000;
         done_irq_o  <= 2'h0;
      end else begin
         done_irq_o <= 2'h0;
         mem_rd_o   <= 1'b0;
         mem_wr_o   <= 1'b0;
         cap_q      <= 2'h0;
         data_q     <= rd_word;
         if (cpu_access_i) begin
            gap_q <= 1'b0;
         end
         // software register writes
         if (wr_en && paddr_i[7:6] == 2'h0) begin
            case (paddr_i[4:0])
               `TCDMA_OFF_CTRL : begin
                  ctrl_q[reg_ch][`TCDMA_CTRL_EN]    <= pwdata_i[`TCDMA_CTRL_EN];
                  ctrl_q[reg_ch][`TCDMA_CTRL_UNIT8] <= pwdata_i[`TCDMA_CTRL_UNIT8];
                  ctrl_q[reg_ch][`TCDMA_CTRL_RPT]   <= pwdata_i[`TCDMA_CTRL_RPT];
                  ctrl_q[reg_ch][`TCDMA_CTRL_SFWD]  <= pwdata_i[`TCDMA_CTRL_SFWD];
                  ctrl_q[reg_ch][`TCDMA_CTRL_DFWD]  <= pwdata_i[`TCDMA_CTRL_DFWD] & ~pwdata_i[`TCDMA_CTRL_SFWD];
                  // writing zero clears the request flag
                  if (!pwdata_i[`TCDMA_CTRL_REQ]) begin
                     ctrl_q[reg_ch][`TCDMA_CTRL_REQ] <= 1'b0;
                  end
                  // enable write arms reload and restart
                  if (pwdata_i[`TCDMA_CTRL_EN]) begin
                     fresh_q[reg_ch] <= 1'b1;
                  end
               end
               `TCDMA_OFF_SEL : sel_q[reg_ch] <= pwdata_i[3:0];
               `TCDMA_OFF_SRC : src_q[reg_ch] <= pwdata_i[19:0];
               `TCDMA_OFF_DST : dst_q[reg_ch] <= pwdata_i[19:0];
               `TCDMA_OFF_RLD : rld_q[reg_ch] <= pwdata_i[15:0];
               default        : ;
            endcase
         end
         if (wr_en && paddr_i == `TCDMA_OFF_BUSCFG) begin
            cfg_q <= pwdata_i;
         end
         // flags set each cycle, both channels alike
         for (i = 0; i < 2; i = i + 1) begin
            if (req_ev[i]) begin
               ctrl_q[i][`TCDMA_CTRL_REQ] <= 1'b1;
            end
         end
         case (st_q)
            ST_IDLE : begin
               if (start) begin
                  ch_q      <= start_ch;
                  bus_req_o <= 1'b1;
                  // flag drops just before the transfer, unless a new request
                  if (!req_ev[start_ch]) begin
                     ctrl_q[start_ch][`TCDMA_CTRL_REQ] <= 1'b0;
                  end
                  // first transfer reloads pointer and counter
                  if (fresh_q[start_ch]) begin
                     fresh_q[start_ch] <= 1'b0;
                     cnt_q[start_ch]   <= rld_q[start_ch];
                     ptr_q[start_ch]   <= ctrl_q[start_ch][`TCDMA_CTRL_SFWD] ? src_q[start_ch] : dst_q[start_ch];
                  end
                  phase_q <= 2'h0;
                  wait_q  <= 2'h0;
                  st_q    <= ST_RD;
               end
            end
            ST_RD : begin
               // each bus cycle lasts its area weight in clocks
               if (wait_q == 2'h0) begin
                  mem_rd_o   <= 1'b1;
                  mem_byte_o <= two_cyc | cur_unit8;
                  mem_addr_o <= cur_src + {19'h0_0000, phase_q[0]};
               end
               if (wait_q == w_src - 2'h1) begin
                  wait_q <= 2'h0;
                  cap_q  <= {1'b1, phase_q[0]};
                  // all reads of the unit before any write
                  if (two_cyc && !phase_q[0]) begin
                     phase_q <= 2'h1;
                  end else begin
                     phase_q <= 2'h0;
                     st_q    <= ST_WR;
                  end
               end else begin
                  wait_q <= wait_q + 2'h1;
               end
            end
            ST_WR : begin
               if (wait_q == 2'h0) begin
                  mem_wr_o    <= 1'b1;
                  mem_byte_o  <= two_cyc | cur_unit8;
                  mem_addr_o  <= cur_dst + {19'h0_0000, phase_q[0]};
                  mem_wdata_o <= phase_q[0] ? {8'h00, rd_word[15:8]} : rd_word;
               end
               if (wait_q == w_dst - 2'h1) begin
                  wait_q <= 2'h0;
                  if (two_cyc && !phase_q[0]) begin
                     phase_q <= 2'h1;
                  end else begin
                     st_q <= ST_GAP;
                  end
               end else begin
                  wait_q <= wait_q + 2'h1;
               end
            end
            ST_GAP : begin
               bus_req_o <= 1'b0;
               gap_q     <= 1'b1;
               st_q      <= ST_IDLE;
               ptr_q[ch_q] <= ptr_q[ch_q] + (cur_unit8 ? 20'h0_0001 : 20'h0_0002);
               if (cnt_q[ch_q] == 16'h0000) begin
                  done_irq_o[ch_q] <= 1'b1;
                  if (ctrl_q[ch_q][`TCDMA_CTRL_RPT]) begin
                     cnt_q[ch_q] <= rld_q[ch_q];
                  end else begin
                     cnt_q[ch_q] <= 16'hFFFF;
                     ctrl_q[ch_q][`TCDMA_CTRL_EN] <= 1'b0;
                  end
               end else begin
                  cnt_q[ch_q] <= cnt_q[ch_q] - 16'h0001;
               end
            end
            default : st_q <= ST_IDLE;
         endcase
      end
   end

   // ******************************************************************
   // apb read side, one wait-free access
   // ******************************************************************
   always @* begin
      rd_mux = 32'h0000_0000;
      if (paddr_i == `TCDMA_OFF_BUSCFG) begin
         rd_mux = cfg_q;
      end else if (paddr_i[7:6] == 2'h0) begin
         case (paddr_i[4:0])
            `TCDMA_OFF_CTRL : rd_mux = {24'h00_0000, ctrl_q[reg_ch]};
            `TCDMA_OFF_SEL  : rd_mux = {28'h000_0000, sel_q[reg_ch]};
            `TCDMA_OFF_SRC  : rd_mux = {12'h000, src_q[reg_ch]};
            `TCDMA_OFF_DST  : rd_mux = {12'h000, dst_q[reg_ch]};
            `TCDMA_OFF_RLD  : rd_mux = {16'h0000, rld_q[reg_ch]};
            `TCDMA_OFF_CNT  : rd_mux = {16'h0000, cnt_q[reg_ch]};
            `TCDMA_OFF_PTR  : rd_mux = {12'h000, ptr_q[reg_ch]};
            default         : rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // read data and error captured in setup, ready one cycle later
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata_o  <= 32'h0000_0000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~((paddr_i == `TCDMA_OFF_BUSCFG) ||
                      (paddr_i[7:6] == 2'h0 && reg_idx != 3'h7));
         if (rd_en) begin
            prdata_o <= rd_mux;
         end
      end
   end
endmodule // tcdma_top

/* File: tcdma_mem_model.sv */
// byte-wide memory model standing on the dma system bus
`timescale 1ns/100ps
module tcdma_mem_model (
   input  wire        clock_i,     // bus clock
   input  wire        mem_rd_i,    // read strobe
   input  wire        mem_wr_i,    // write strobe
   input  wire        mem_byte_i,  // byte wide cycle
   input  wire [19:0] mem_addr_i,  // bus address
   input  wire [15:0] mem_wdata_i, // write data
   output wire [15:0] mem_rdata_o  // read data
);
   reg  [7:0]  mem_q [0:255];
   reg         valid_q;
   wire [7:0]  a = mem_addr_i[7:0];
   wire [15:0] d = {mem_q[a + 8'h01], mem_q[a]};
   integer     i;
   // fill with a pattern the bench can recompute
   initial begin
      valid_q = 1'b0;
      for (i = 0; i < 256; i = i + 1)
         mem_q[i] = i[7:0] ^ 8'hA5;
   end
   // data from a read cycle until the next write, inverted otherwise so stale values never match
   assign mem_rdata_o = (mem_rd_i || valid_q) ? d : ~d;
   // low byte at the address, high byte above it
   always @(posedge clock_i) begin
      if (mem_rd_i)
         valid_q <= 1'b1;
      else if (mem_wr_i)
         valid_q <= 1'b0;
      if (mem_wr_i) begin
         mem_q[a] <= mem_wdata_i[7:0];
         if (!mem_byte_i)
            mem_q[a + 8'h01] <= mem_wdata_i[15:8];
      end
   end
endmodule // tcdma_mem_model

/* File: tcdma_checker.sv */
// port assertions of the dma controller
`timescale 1ns/100ps
module tcdma_checker (
   input wire       clock_i,      // bus clock
   input wire       reset_n_i,    // async reset, active low
   input wire       psel_i,       // apb select
   input wire       penable_i,    // apb enable
   input wire       pready_o,     // apb ready
   input wire       cpu_access_i, // cpu access done
   input wire       bus_req_o,    // dma owns bus
   input wire       mem_rd_o,     // read strobe
   input wire       mem_wr_o,     // write strobe
   input wire [1:0] done_irq_o    // underflow pulses
);
   reg  wait_q;
   wire wait_w = wait_q && !cpu_access_i;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   // owed a cpu access once the bus was held
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i)
         wait_q <= 1'b0;
      else
         wait_q <= bus_req_o ? 1'b1 : wait_w;
   end
   property p_ready; psel_i && !penable_i |=> pready_o; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_first_rd; $rose(bus_req_o) |=> mem_rd_o && !mem_wr_o; endproperty
   a_first_rd: assert property (p_first_rd) else $error("unit not opened by read");
   property p_strobe; mem_rd_o || mem_wr_o |-> bus_req_o && !(mem_rd_o && mem_wr_o); endproperty
   a_strobe: assert property (p_strobe) else $error("strobe outside bus hold");
   property p_done_fall; done_irq_o != 2'b00 |-> !bus_req_o && $past(bus_req_o); endproperty
   a_done_fall: assert property (p_done_fall) else $error("done pulse off unit end");
   property p_done_pulse; done_irq_o != 2'b00 |=> done_irq_o == 2'b00; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
   property p_cpu_gap; $rose(bus_req_o) |-> !$past(wait_w); endproperty
   a_cpu_gap: assert property (p_cpu_gap) else $error("bus retaken without cpu access");
   property p_unit_len; $rose(bus_req_o) |-> ##[3:13] !bus_req_o; endproperty
   a_unit_len: assert property (p_unit_len) else $error("unit length out of range");
   property p_one_done; $onehot0(done_irq_o); endproperty
   a_one_done: assert property (p_one_done) else $error("two channels done at once");
   c_unit: cover property ($rose(bus_req_o));
   c_done1: cover property (done_irq_o[1]);
   c_b2b: cover property ($fell(bus_req_o) ##[1:40] $rose(bus_req_o));
endmodule // tcdma_checker
bind tcdma_top tcdma_checker tcdma_checker_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pready_o(pready_o), .cpu_access_i(cpu_access_i), .bus_req_o(bus_req_o),
   .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .done_irq_o(done_irq_o));

/* File: tcdma_top_tb.sv */
// self-checking bench for the two-channel dma controller
`timescale 1ns/100ps
`include "tcdma_regs.vh"
module tcdma_top_tb;
   reg         clock_i = 1'b0, reset_n_i = 1'b0;
   reg         psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, cpu_access_i = 1'b0;
   reg  [7:0]  paddr_i = 8'h00, peri_irq_i = 8'h00;
   reg  [31:0] pwdata_i = 32'h0, rdat;
   reg  [1:0]  ext_int_i = 2'b11;
   wire [31:0] prdata_o;
   wire        pready_o, pslverr_o, bus_req_o, mem_rd_o, mem_wr_o, mem_byte_o;
   wire [19:0] mem_addr_o;
   wire [15:0] mem_wdata_o, mem_rdata_i;
   wire [1:0]  done_irq_o;
   reg         er, wr_seen = 1'b0, in_unit = 1'b0;
   reg  [19:0] first_q [$];
   integer     num_errors = 0, checks_done = 0, n_rd = 0, n_wr = 0, n_clk = 0, n_d0 = 0, i;
   tcdma_top #(.NPERI(8)) tcdma_top_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .peri_irq_i(peri_irq_i), .ext_int_i(ext_int_i),
      .cpu_access_i(cpu_access_i), .bus_req_o(bus_req_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
      .mem_byte_o(mem_byte_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
      .done_irq_o(done_irq_o));
   tcdma_mem_model tcdma_mem_model_inst (.clock_i(clock_i), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
      .mem_byte_i(mem_byte_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
   always #4 clock_i = ~clock_i;
   // bus monitor, values sampled as they stood before the edge
   always @(posedge clock_i) begin
      if (bus_req_o === 1'b1)
         n_clk = n_clk + 1;
      else begin
         wr_seen = 1'b0;
         in_unit = 1'b0;
      end
      if (mem_rd_o === 1'b1) begin
         if (!in_unit)
            first_q.push_back(mem_addr_o);
         in_unit = 1'b1;
         if (wr_seen)
            check(1, 0);
         n_rd = n_rd + 1;
      end
      if (mem_wr_o === 1'b1) begin
         wr_seen = 1'b1;
         n_wr = n_wr + 1;
      end
      n_d0 = n_d0 + done_irq_o[0];
   end
   task check(input [31:0] seen, input [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      if (num_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // apb transfer, request held until ready is sampled
   task apb(input w, input [7:0] a, input [31:0] d);
      integer k;
      begin
         @(posedge clock_i);
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge clock_i);
         penable_i <= 1'b1;
         k = 0;
         do begin @(posedge clock_i); k = k + 1; end while (pready_o !== 1'b1 && k < 20);
         if (k >= 20) begin check(0, 1); end_of_test; end
         rdat = prdata_o;
         er = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   task w(input [7:0] a, input [31:0] d); apb(1'b1, a, d); endtask
   task r(input [7:0] a); apb(1'b0, a, 32'h0); endtask
   // wait one unit, then give the cpu its bus access
   task unit;
      integer k;
      begin
         k = 0;
         do begin @(posedge clock_i); k = k + 1; end while (bus_req_o !== 1'b1 && k < 100);
         do begin @(posedge clock_i); k = k + 1; end while (bus_req_o !== 1'b0 && k < 200);
         if (k >= 200 || k < 2) begin check(0, 1); end_of_test; end
         cpu_access_i <= 1'b1;
         @(posedge clock_i);
         cpu_access_i <= 1'b0;
      end
   endtask
   task peri3; begin peri_irq_i <= 8'h08; @(posedge clock_i); peri_irq_i <= 8'h00; unit; end endtask
   function integer wt(input [2:0] a);
      wt = (a == `TCDMA_AREA_MUX) ? 3 : (a == `TCDMA_AREA_INT || a == `TCDMA_AREA_SEP) ? 1 : 2;
   endfunction
   // one software-started unit on channel zero with a given bus setup
   task run(input u8, input [1:0] cfg, input [7:0] s, d, input [2:0] sa, da, input integer nb);
      begin
         w(`TCDMA_OFF_BUSCFG, {17'h00000, da, 1'b0, sa, 6'h00, cfg});
         w(`TCDMA_OFF_SRC, {24'h000000, s});
         w(`TCDMA_OFF_DST, {24'h000000, d});
         w(`TCDMA_OFF_RLD, 32'h0);
         n_rd = 0; n_wr = 0; n_clk = 0; n_d0 = 0;
         w(`TCDMA_OFF_CTRL, {25'h0000000, 1'b1, 1'b0, 1'b1, 1'b0, u8, 1'b0, 1'b1});
         unit;
         check(n_rd, nb);
         check(n_wr, nb);
         check(n_clk, nb * (wt(sa) + wt(da)) + 1);
         check(tcdma_mem_model_inst.mem_q[d], s ^ 8'hA5);
         if (!u8) check(tcdma_mem_model_inst.mem_q[d + 8'h01], (s + 8'h01) ^ 8'hA5);
         check(n_d0, 1);
         r(`TCDMA_OFF_CTRL);
         check(rdat[0], 1'b0);
      end
   endtask
   initial begin
      repeat (16) @(posedge clock_i);
      reset_n_i <= 1'b1;
      r(`TCDMA_OFF_CTRL);
      check(rdat, {24'h000000, `TCDMA_RST_CTRL});
      r(`TCDMA_OFF_BUSCFG);
      check(rdat, `TCDMA_RST_BUSCFG);
      r(8'h3C);
      check(er, 1'b1);
      check(rdat, 32'h0);
      // every area code and unit count case
      run(1'b1, 2'b01, 8'h11, 8'h81, `TCDMA_AREA_INT, `TCDMA_AREA_INT, 1);
      run(1'b0, 2'b01, 8'h14, 8'h84, `TCDMA_AREA_INTW, `TCDMA_AREA_SFA, 1);
      run(1'b0, 2'b01, 8'h23, 8'h87, `TCDMA_AREA_SEP, `TCDMA_AREA_SEPW, 2);
      run(1'b0, 2'b10, 8'h30, 8'h90, `TCDMA_AREA_MUX, `TCDMA_AREA_INT, 2);
      run(1'b1, 2'b10, 8'h37, 8'h97, `TCDMA_AREA_SEPW, `TCDMA_AREA_MUX, 1);
      // repeat mode on a peripheral line, then enable rewrite
      w(`TCDMA_OFF_BUSCFG, `TCDMA_RST_BUSCFG);
      w(`TCDMA_OFF_SRC, 32'h40);
      w(`TCDMA_OFF_RLD, 32'h1);
      w(`TCDMA_OFF_SEL, {28'h0000000, `TCDMA_SEL_PERI0 | 4'h3});
      w(`TCDMA_OFF_CTRL, 32'h1D);
      n_d0 = 0;
      peri3;
      r(`TCDMA_OFF_CNT);
      check(rdat, 32'h0);
      r(`TCDMA_OFF_PTR);
      check(rdat, 32'h41);
      check(n_d0, 0);
      peri3;
      check(n_d0, 1);
      r(`TCDMA_OFF_CNT);
      check(rdat, 32'h1);
      r(`TCDMA_OFF_CTRL);
      check(rdat[0], 1'b1);
      w(`TCDMA_OFF_CTRL, 32'h1D);
      peri3;
      r(`TCDMA_OFF_PTR);
      check(rdat, 32'h41);
      r(`TCDMA_OFF_CNT);
      check(rdat, 32'h0);
      w(`TCDMA_OFF_CTRL, 32'h0);
      // flag on a disabled channel, software clear only
      n_clk = 0;
      w(`TCDMA_CH_STRIDE + `TCDMA_OFF_SEL, {28'h0000000, `TCDMA_SEL_SW});
      w(`TCDMA_CH_STRIDE + `TCDMA_OFF_CTRL, 32'h40);
      r(`TCDMA_CH_STRIDE + `TCDMA_OFF_CTRL);
      check(rdat[1], 1'b1);
      check(n_clk, 0);
      w(`TCDMA_CH_STRIDE + `TCDMA_OFF_CTRL, 32'h0);
      r(`TCDMA_CH_STRIDE + `TCDMA_OFF_CTRL);
      check(rdat[1], 1'b0);
      w(`TCDMA_CH_STRIDE + `TCDMA_OFF_CTRL, 32'h2);
      r(`TCDMA_CH_STRIDE + `TCDMA_OFF_CTRL);
      check(rdat[1], 1'b0);
      // both pins fall together, channel zero served first
      w(`TCDMA_OFF_SRC, 32'h50);
      w(`TCDMA_OFF_DST, 32'hA0);
      w(`TCDMA_OFF_RLD, 32'h0);
      w(`TCDMA_CH_STRIDE + `TCDMA_OFF_SRC, 32'h60);
      w(`TCDMA_CH_STRIDE + `TCDMA_OFF_DST, 32'hB0);
      w(`TCDMA_CH_STRIDE + `TCDMA_OFF_RLD, 32'h0);
      w(`TCDMA_OFF_SEL, {28'h0000000, `TCDMA_SEL_EXTFALL});
      w(`TCDMA_CH_STRIDE + `TCDMA_OFF_SEL, {28'h0000000, `TCDMA_SEL_EXTBOTH});
      w(`TCDMA_OFF_CTRL, 32'h15);
      w(`TCDMA_CH_STRIDE + `TCDMA_OFF_CTRL, 32'h15);
      first_q.delete();
      ext_int_i <= 2'b00;
      unit;
      unit;
      check(first_q.size(), 2);
      check(first_q[0], 20'h00050);
      check(first_q[1], 20'h00060);
      r(`TCDMA_OFF_CTRL);
      check(rdat[1], 1'b0);
      // rising edge counts only for the both-edges channel
      ext_int_i <= 2'b11;
      rdat = 32'h0;
      for (i = 0; i < 8 && rdat[1] !== 1'b1; i = i + 1)
         r(`TCDMA_CH_STRIDE + `TCDMA_OFF_CTRL);
      check(rdat[1], 1'b1);
      r(`TCDMA_OFF_CTRL);
      check(rdat[1], 1'b0);
      end_of_test;
   end
endmodule // tcdma_top_tb
